// ===== hw/ups_pkg.sv
package ups_pkg;
    // opmode codes
    localparam logic [1:0] UPS_OPM_NORMAL = 2'h0;
    localparam logic [1:0] UPS_OPM_NODRIVE = 2'h1;
    localparam logic [1:0] UPS_OPM_CHIRP = 2'h2;
    localparam logic [1:0] UPS_OPM_RAW = 2'h3;
    // linestate codes
    localparam logic [1:0] UPS_LS_SE0 = 2'h0;
    localparam logic [1:0] UPS_LS_J = 2'h1;
    localparam logic [1:0] UPS_LS_K = 2'h2;
    // special bytes in raw mode
    localparam logic [7:0] UPS_STP_NOSTUFF = 8'hfe;
    localparam logic [7:0] UPS_STP_NOEOP = 8'h00;
    localparam logic [7:0] UPS_PID_SOF = 8'ha5;
    // id detection time
    localparam int UPS_T_ID_US = 50;
    localparam int UPS_CLK_MHZ = 100;
    localparam int UPS_ID_CYC = UPS_T_ID_US * UPS_CLK_MHZ;
    // rxcmd hold after wake; the clock restarts at once
    localparam int UPS_CLK_RESTART_CYC = 4;
    localparam int UPS_RXCMD_W = 8;
    // rxcmd bit positions
    localparam int UPS_RX_LS_LSB = 0;
    localparam int UPS_RX_VBUS_LSB = 2;
    localparam int UPS_RX_ID_BIT = 6;

    typedef struct packed {
        logic vbus_valid;
        logic sess_valid;
        logic sess_end;
        logic id;
    } ups_cmp_t;

    typedef enum logic [2:0] {
        UPS_EOP_NORMAL = 3'h0,
        UPS_EOP_NOSTUFF = 3'h1,
        UPS_EOP_NONE = 3'h2,
        UPS_EOP_LONG = 3'h3,
        UPS_EOP_NOSYNC = 3'h4
    } ups_eop_t;
endpackage

// ===== hw/ups_sync.sv
module ups_sync
    import ups_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // change accepted once second and third stages agree
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            dout <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule

// ===== hw/ups_phy_ctrl.sv
module ups_phy_ctrl
    import ups_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // function control from link
    input wire logic suspendm,
    input wire logic [1:0] opmode,
    input wire logic [1:0] xcvrselect,
    input wire logic termselect,
    input wire logic dp_pulldown,
    input wire logic dm_pulldown,
    input wire logic id_sense_pullup_enable,
    input wire logic three_wire_serial_select,
    // transmit stream from link
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic stp,
    // analog side, asynchronous
    input wire logic [1:0] line_state_raw,
    input wire logic vbus_valid_raw,
    input wire logic sess_valid_raw,
    input wire logic sess_end_raw,
    input wire logic id_raw,
    // status and controls toward analog
    output logic suspended,
    output logic clk_out_en,
    output logic serial_mode,
    output logic auto_sync_eop,
    output logic nrzi_stuff_en,
    output logic eop_stuff_en,
    output logic eop_send,
    output logic eop_long,
    output logic resume_eop,
    // receive command toward link
    output logic rxcmd_valid,
    output logic [UPS_RXCMD_W-1:0] rxcmd_data
);
    ////////////////////////////////////////////////////////////////////
    logic [5:0] sync_in;
    logic [5:0] sync_out;
    ups_cmp_t cmp;
    ups_cmp_t cmp_prev;
    logic [1:0] ls;
    logic [1:0] ls_prev;
    logic susp_req_prev;
    logic [2:0] restart_cnt;
    logic restarting;
    logic sof_pkt;
    logic first_byte;
    logic resume_drive;
    logic resume_drive_prev;
    logic id_armed;
    logic [12:0] id_cnt;
    ups_eop_t eop_kind;

    assign sync_in = {line_state_raw, vbus_valid_raw, sess_valid_raw, sess_end_raw, id_raw};

    ups_sync #(.W(6)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din(sync_in),
        .dout(sync_out)
    );

    assign ls = sync_out[5:4];
    assign cmp = ups_cmp_t'(sync_out[3:0]);

    ////////////////////////////////////////////////////////////////////
    // suspend and wake
    wire suspend_enter = !suspendm && susp_req_prev && !suspended;
    wire wake_evt = suspended && (stp || suspendm);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            suspended <= 1'b0;
            susp_req_prev <= 1'b1;
            restart_cnt <= 3'h0;
        end else begin
            susp_req_prev <= suspendm;
            if (suspend_enter) begin
                suspended <= 1'b1;
            end else if (wake_evt) begin
                suspended <= 1'b0;
                restart_cnt <= 3'(UPS_CLK_RESTART_CYC);
            end else if (restart_cnt != 3'h0) begin
                restart_cnt <= restart_cnt - 3'h1;
            end
        end
    end

    // clock comes back first; rxcmds held until the restart count runs out
    assign restarting = restart_cnt != 3'h0;
    assign clk_out_en = !suspended;

    ////////////////////////////////////////////////////////////////////
    // transmit mode control
    wire raw_mode = opmode == UPS_OPM_RAW;
    wire hs_sel = xcvrselect == 2'h0;
    assign auto_sync_eop = !(raw_mode && hs_sel);
    assign nrzi_stuff_en = 1'b1;
    assign serial_mode = three_wire_serial_select && !hs_sel;

    wire tx_first = tx_valid && first_byte;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            first_byte <= 1'b1;
            sof_pkt <= 1'b0;
        end else if (stp) begin
            first_byte <= 1'b1;
        end else if (tx_first) begin
            first_byte <= 1'b0;
            sof_pkt <= tx_data == UPS_PID_SOF;
        end
    end

    // eop treatment decided on stp data in raw high-speed mode
    wire raw_hs = raw_mode && hs_sel;
    assign eop_kind = !raw_hs ? UPS_EOP_NORMAL :
                      (tx_data == UPS_STP_NOEOP) ? UPS_EOP_NONE :
                      (tx_data == UPS_STP_NOSTUFF) ? UPS_EOP_NOSTUFF :
                      sof_pkt ? UPS_EOP_LONG : UPS_EOP_NOSYNC;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            eop_send <= 1'b0;
            eop_long <= 1'b0;
            eop_stuff_en <= 1'b1;
        end else begin
            eop_send <= stp && !suspended && (eop_kind != UPS_EOP_NONE);
            eop_long <= stp && (eop_kind == UPS_EOP_LONG);
            eop_stuff_en <= !(stp && eop_kind == UPS_EOP_NOSTUFF);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // resume end: host side (pull-downs on) appends eop when drive stops
    assign resume_drive = opmode == UPS_OPM_CHIRP && !suspended;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            resume_drive_prev <= 1'b0;
            resume_eop <= 1'b0;
        end else begin
            resume_drive_prev <= resume_drive;
            resume_eop <= resume_drive_prev && (stp || !resume_drive)
                          && dp_pulldown && dm_pulldown;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive commands: linestate, comparator and id changes
    wire cmp_chg = (cmp.vbus_valid != cmp_prev.vbus_valid)
                || (cmp.sess_valid != cmp_prev.sess_valid)
                || (cmp.sess_end != cmp_prev.sess_end);
    wire id_chg = id_armed && (cmp.id != cmp_prev.id);
    wire ls_chg = ls != ls_prev;
    // no updates while driving resume K; the link assumes K meanwhile
    wire quiet = suspended || restarting || resume_drive;
    wire send = !quiet && (cmp_chg || id_chg || ls_chg || id_cnt == 13'h1);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            id_armed <= 1'b0;
            id_cnt <= 13'h0;
        end else if (!id_sense_pullup_enable) begin
            id_armed <= 1'b0;
            id_cnt <= 13'h0;
        end else if (!id_armed) begin
            // pull-up settle, then one forced report within detection time
            id_armed <= 1'b1;
            id_cnt <= 13'(UPS_ID_CYC);
        end else if (id_cnt != 13'h0) begin
            id_cnt <= id_cnt - 13'h1;
        end
    end

    // changes seen while quiet are kept pending by not updating prev
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmp_prev <= '0;
            ls_prev <= UPS_LS_SE0;
            rxcmd_valid <= 1'b0;
            rxcmd_data <= '0;
        end else begin
            rxcmd_valid <= send;
            if (send) begin
                cmp_prev <= cmp;
                ls_prev <= ls;
                rxcmd_data <= {1'b0, cmp.id && id_armed, 1'b0, cmp.sess_end,
                               cmp.vbus_valid, cmp.sess_valid, ls};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    suspend_wake_a: assert property (@(posedge sys_clk) disable iff (rst)
        suspended && stp |=> !suspended ##0 clk_out_en) else $error("no wake on stp");
    suspend_enter_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(suspendm) && !suspended |=> suspended) else $error("no suspend");
    clk_first_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(suspended) |-> !rxcmd_valid[*4]) else $error("rxcmd before clock");
    raw_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
        opmode == UPS_OPM_RAW && xcvrselect == 2'h0 |-> !auto_sync_eop && nrzi_stuff_en)
        else $error("raw mode wrong");
    no_eop_a: assert property (@(posedge sys_clk) disable iff (rst)
        stp && raw_hs && tx_data == UPS_STP_NOEOP |=> !eop_send) else $error("eop sent");
    nostuff_eop_a: assert property (@(posedge sys_clk) disable iff (rst)
        stp && raw_hs && tx_data == UPS_STP_NOSTUFF |=> !eop_stuff_en)
        else $error("eop stuffed");
    sof_long_a: assert property (@(posedge sys_clk) disable iff (rst)
        tx_first && raw_hs && tx_data == UPS_PID_SOF && !stp ##1 stp && !tx_valid && raw_hs
        && tx_data != UPS_STP_NOEOP && tx_data != UPS_STP_NOSTUFF |=> eop_long)
        else $error("no long eop");
    quiet_resume_a: assert property (@(posedge sys_clk) disable iff (rst)
        resume_drive |=> !rxcmd_valid) else $error("rxcmd during resume");
    serial_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
        three_wire_serial_select && xcvrselect == 2'h1 |-> serial_mode)
        else $error("no serial mode");
    cmp_report_a: assert property (@(posedge sys_clk) disable iff (rst)
        cmp_chg && !quiet |=> rxcmd_valid
        ##0 rxcmd_data[4:2] == $past({cmp.sess_end, cmp.vbus_valid, cmp.sess_valid}))
        else $error("comparator change lost");
    resume_eop_a: assert property (@(posedge sys_clk) disable iff (rst)
        resume_drive ##1 !resume_drive && dp_pulldown && dm_pulldown |=> resume_eop)
        else $error("no resume eop");
endmodule

// ===== tb/ups_link_model.sv
module ups_link_model
    import ups_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // phy state seen by the link
    input wire logic suspended,
    input wire logic [1:0] line_state_raw,
    // function control toward phy
    output logic suspendm,
    output logic [1:0] opmode,
    output logic [1:0] xcvrselect,
    output logic termselect,
    output logic dp_pulldown,
    output logic dm_pulldown,
    output logic id_sense_pullup_enable,
    output logic three_wire_serial_select,
    // transmit stream
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic stp
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {suspendm, opmode, xcvrselect, termselect} = 6'h20;
        {dp_pulldown, dm_pulldown} = 2'h3;
        {id_sense_pullup_enable, three_wire_serial_select, tx_valid, stp} = 4'h0;
        tx_data = 8'h00;
    end

    ////////////////////////////////////////////////////////////
    // asleep there is no rxcmd, so the link reads the wire itself
    always @(posedge sys_clk) begin
        if (!rst && suspended && line_state_raw == UPS_LS_K) begin
            #1 stp = 1'h1;
            @(posedge sys_clk);
            #1 stp = 1'h0;
        end
    end

    task automatic set_mode(input logic [1:0] op, input logic [1:0] xs, input logic ts,
            input logic ser, input logic idp);
        {opmode, xcvrselect, termselect} = {op, xs, ts};
        {three_wire_serial_select, id_sense_pullup_enable} = {ser, idp};
    endtask

    // full-speed switch must land before the suspend request
    task automatic go_suspend();
        {xcvrselect, termselect} = 3'h3;
        @(posedge sys_clk);
        #1 suspendm = 1'h0;
    endtask

    task automatic remote_wake();
        suspendm = 1'h1;
        @(posedge sys_clk);
        #1 opmode = UPS_OPM_CHIRP;
        repeat (5) @(posedge sys_clk);
        #1 opmode = UPS_OPM_NORMAL;
    endtask

    task automatic hs_return();
        {xcvrselect, termselect} = 3'h0;
        @(posedge sys_clk);
        #1 opmode = UPS_OPM_NORMAL;
    endtask

    task automatic tx_byte(input logic [7:0] d);
        tx_valid = 1'h1;
        tx_data = d;
        @(posedge sys_clk);
        #1 tx_valid = 1'h0;
    endtask

    task automatic stop(input logic [7:0] d);
        stp = 1'h1;
        tx_data = d;
        @(posedge sys_clk);
        #1 stp = 1'h0;
    endtask
endmodule

// ===== tb/tb_ulpi_phy_suspend_resume_ctrl.sv
module tb_ulpi_phy_suspend_resume_ctrl
    import ups_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk, rst, suspendm, termselect, dp_pulldown, dm_pulldown, id_sense_pullup_enable;
    logic three_wire_serial_select, tx_valid, stp, suspended, clk_out_en, serial_mode, got;
    logic auto_sync_eop, nrzi_stuff_en, eop_stuff_en, eop_send, eop_long, resume_eop, rxcmd_valid;
    logic [1:0] opmode, xcvrselect, line_state_raw;
    logic [7:0] tx_data, rxcmd_data, pid, last;
    ups_cmp_t cmp;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;

    ups_phy_ctrl uut (.sys_clk, .rst, .suspendm, .opmode, .xcvrselect, .termselect,
        .dp_pulldown, .dm_pulldown, .id_sense_pullup_enable, .three_wire_serial_select,
        .tx_valid, .tx_data, .stp, .line_state_raw, .vbus_valid_raw(cmp.vbus_valid),
        .sess_valid_raw(cmp.sess_valid), .sess_end_raw(cmp.sess_end), .id_raw(cmp.id),
        .suspended, .clk_out_en, .serial_mode, .auto_sync_eop, .nrzi_stuff_en, .eop_stuff_en,
        .eop_send, .eop_long, .resume_eop, .rxcmd_valid, .rxcmd_data);

    ups_link_model link (.sys_clk, .rst, .suspended, .line_state_raw, .suspendm, .opmode,
        .xcvrselect, .termselect, .dp_pulldown, .dm_pulldown, .id_sense_pullup_enable,
        .three_wire_serial_select, .tx_valid, .tx_data, .stp);

    function automatic logic [7:0] exp_cmp(ups_cmp_t c);
        return {3'h0, c.sess_end, c.vbus_valid, c.sess_valid, 2'h0};
    endfunction

    // {send, long, stuff} after stp in raw mode
    function automatic logic [2:0] exp_eop(logic [7:0] p, logic [7:0] l);
        if (l == UPS_STP_NOEOP) return 3'h1;
        return {1'h1, p == UPS_PID_SOF, l != UPS_STP_NOSTUFF};
    endfunction

    task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
        n_tests++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            mismatches++;
        end
    endtask

    task automatic wait_rx(int lim);
        got = (rxcmd_valid === 1'h1);
        for (int i = 0; i < lim && !got; i++) begin
            @(posedge sys_clk);
            #1 got = (rxcmd_valid === 1'h1);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        {rst, line_state_raw, cmp} = 7'h40;
        void'($urandom(50028));
        repeat (8) @(posedge sys_clk);
        #1 rst = 1'h0;
        chk("suspended", 0, suspended);
        chk("clk_out_en", 1, clk_out_en);
        chk("eop_stuff_en", 1, eop_stuff_en);
        // comparator flips, random but never a no-op
        for (int i = 0; i < 12; i++) begin
            @(posedge sys_clk);
            #1 cmp[3:1] = cmp[3:1] ^ 3'($urandom_range(7, 1));
            wait_rx(20);
            chk("rxcmd_seen", 1, got);
            chk("rxcmd_cmp", exp_cmp(cmp), rxcmd_data & 8'h1c);
        end
        link.set_mode(UPS_OPM_NORMAL, 2'h0, 1'h0, 1'h0, 1'h1);
        @(posedge sys_clk);
        #1 cmp.id = 1'h1;
        wait_rx(UPS_ID_CYC + 20);
        chk("rxcmd_seen", 1, got);
        chk("rxcmd_id", 8'h40, rxcmd_data & 8'h40);
        // let the forced report at the end of the sense window pass
        repeat (UPS_ID_CYC + 20) @(posedge sys_clk);
        #1 link.go_suspend();
        repeat (2) @(posedge sys_clk);
        #1 chk("suspended", 1, suspended);
        chk("clk_out_en", 0, clk_out_en);
        line_state_raw = UPS_LS_K;
        for (int i = 0; i < 20 && suspended !== 1'h0; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk("suspended", 0, suspended);
        chk("clk_out_en", 1, clk_out_en);
        repeat (3) begin
            chk("rxcmd_valid", 0, rxcmd_valid);
            @(posedge sys_clk);
            #1;
        end
        wait_rx(20);
        chk("rxcmd_ls", UPS_LS_K, rxcmd_data & 8'h03);
        link.hs_return();
        line_state_raw = UPS_LS_SE0;
        link.go_suspend();
        repeat (2) @(posedge sys_clk);
        #1 link.remote_wake();
        chk("suspended", 0, suspended);
        @(posedge sys_clk);
        #1 chk("resume_eop", 1, resume_eop);
        link.set_mode(UPS_OPM_RAW, 2'h0, 1'h0, 1'h0, 1'h1);
        @(posedge sys_clk);
        #1 chk("auto_sync_eop", 0, auto_sync_eop);
        chk("nrzi_stuff_en", 1, nrzi_stuff_en);
        for (int i = 0; i < 8; i++) begin
            pid = (i % 4 == 0) ? UPS_PID_SOF : 8'($urandom_range(255, 166));
            last = (i % 4 == 1) ? UPS_STP_NOSTUFF : 8'($urandom_range(253, 1));
            if (i % 4 == 2) last = UPS_STP_NOEOP;
            link.tx_byte(pid);
            link.stop(last);
            chk("eop_flags", exp_eop(pid, last), {eop_send, eop_long, eop_stuff_en});
        end
        link.set_mode(UPS_OPM_NORMAL, 2'h1, 1'h1, 1'h1, 1'h1);
        @(posedge sys_clk);
        #1 chk("serial_mode", 1, serial_mode);
        chk("auto_sync_eop", 1, auto_sync_eop);
        link.set_mode(UPS_OPM_NORMAL, 2'h0, 1'h0, 1'h1, 1'h1);
        @(posedge sys_clk);
        #1 chk("serial_mode", 0, serial_mode);
        end_sim();
    end
endmodule
